// ### common/sysint_pkg.sv
// Purpose: Shared constants for the supply monitor and reset flag block.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes: Byte offsets, field positions, reset values and delay counts live here.
// How it works
// - Comparator result shows as read-only live flag in control/status bit 5.
// - Auxiliary detection runs only while the low-voltage detector option is on.
// - Bit 7 selects comparator input: 0 main supply, 1 external detect pin.
// - With enable bit 6 set, every flag change, rise or fall, requests an interrupt.
// - Pending request clears by hardware when the CPU enters its service routine.
// - Flag reads 0 above rising threshold and 1 below falling threshold.
// - Flag changes inside the 256 or 4096 cycle reset delay raise no interrupt.
// - Slow rise with early enable gives two interrupts: at enable and at threshold.
// - Enable set after the threshold already crossed gives exactly one interrupt.
// - In wait mode the unit runs and its interrupt wakes the device.
// - In halt mode the register is frozen and no wakeup is produced.
// - Request reaches the CPU only when enabled and CPU interrupt mask clear.
// - Bit 4 set by low-voltage reset, cleared only by software writing zero.
// - Pin and watchdog resets leave the low-voltage reset flag unchanged.
// - Bit 0 set by watchdog reset, cleared by zero write or low-voltage reset.
// - Control and reserved bits reset to zero; flag bits follow hardware.
package sysint_pkg;
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
  localparam int BIT_SRC_SEL = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_AUX_FLAG = 5;
  localparam int BIT_LV_RST = 4;
  localparam int BIT_WDG_RST = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int IRQ_BIT_AUX = 0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_BIT_RESET_CAUSE = 1;
  localparam int RESET_DELAY_SHORT = 256;
  localparam int RESET_DELAY_LONG = 4096;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    PH_DELAY,
    PH_RUN
  } phase_type;
endpackage : sysint_pkg

// ### design/supply_monitor_reset_flags.sv
// Purpose: Auxiliary voltage monitor flag, change interrupt and reset cause flags.
// Assumes: Comparator output is asynchronous; other inputs are synchronous to aclk.
// Notes: Reset flags survive aresetn and are loaded from cause inputs during reset.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module supply_monitor_reset_flags
  import sysint_pkg::*;
#(
  parameter int DELAY_SHORT = RESET_DELAY_SHORT,
  parameter int DELAY_LONG = RESET_DELAY_LONG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_out,
  input wire logic lvd_option_enable,
  input wire logic reset_delay_long,
  input wire logic lvd_reset_cause,
  input wire logic watchdog_reset_cause,
  input wire logic cpu_interrupt_mask,
  input wire logic isr_enter,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic monitor_source_select,
  output logic detector_enable,
  output logic aux_irq_request,
  output logic wakeup_request,
  output logic irq
);

  logic sync1_q, sync2_q;
  logic flag_q, flag_d;
  logic src_sel_q, src_sel_d;
  logic irq_en_q, irq_en_d;
  logic lv_rst_q, lv_rst_d;
  logic wdg_rst_q, wdg_rst_d;
  logic pending_q, pending_d;
  logic [1:0] irq_stat_q, irq_stat_d;
  logic [1:0] irq_mask_q, irq_mask_d;
  logic [12:0] dly_cnt_q, dly_cnt_d;
  phase_type phase_q, phase_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire, rd_fire, aux_event, en_rise, flag_change;
  logic [7:0] ctrl_view;
  logic [12:0] dly_len;

  // Two-stage synchronizer; the first stage feeds only the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= comparator_out;
      sync2_q <= sync1_q;
    end
  end

  // Control/status view: source select, enable, live flag, reset flags.
  assign ctrl_view = {src_sel_q, irq_en_q, flag_q, lv_rst_q, 3'h0, wdg_rst_q};

  // AXI handshake: a write is taken when address and data are both offered.
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Bus response channel next values.
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = (s_axi_awaddr == OFS_CTRL_STATUS || s_axi_awaddr == OFS_IRQ_STATUS ||
                 s_axi_awaddr == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL_STATUS: rdata_d = {24'h000000, ctrl_view};
        OFS_IRQ_STATUS: rdata_d = {30'h00000000, irq_stat_q};
        OFS_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Reset delay phase after release; flag changes in it raise nothing.
  assign dly_len = reset_delay_long ? 13'(DELAY_LONG) : 13'(DELAY_SHORT);
  always_comb begin
    phase_d = phase_q;
    dly_cnt_d = dly_cnt_q;
    unique case (phase_q)
      PH_DELAY: begin
        dly_cnt_d = dly_cnt_q + 13'h0001;
        if (dly_cnt_q == dly_len - 13'h0001) begin
          phase_d = PH_RUN;
        end
      end
      PH_RUN: dly_cnt_d = dly_cnt_q;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PH_DELAY;
      dly_cnt_q <= 13'h0000;
    end else begin
      phase_q <= phase_d;
      dly_cnt_q <= dly_cnt_d;
    end
  end

  // Events: flag toggles and the enable being turned on, both after the delay.
  assign flag_change = (flag_d != flag_q);
  assign en_rise = irq_en_d && !irq_en_q;
  assign aux_event = (phase_q == PH_RUN) && (flag_change || en_rise);

  // Control/status register and pending request next values; register frozen in halt, pending still cleared by isr_enter.
  always_comb begin
    src_sel_d = src_sel_q;
    irq_en_d = irq_en_q;
    lv_rst_d = lv_rst_q;
    wdg_rst_d = wdg_rst_q;
    flag_d = lvd_option_enable ? sync2_q : 1'b0;
    pending_d = pending_q;
    if (halt_mode) begin
      flag_d = flag_q;
    end else if (wr_fire && s_axi_awaddr == OFS_CTRL_STATUS && s_axi_wstrb[0]) begin
      src_sel_d = s_axi_wdata[BIT_SRC_SEL];
      irq_en_d = s_axi_wdata[BIT_IRQ_EN];
      if (!s_axi_wdata[BIT_LV_RST]) begin
        lv_rst_d = 1'b0;
      end
      if (!s_axi_wdata[BIT_WDG_RST]) begin
        wdg_rst_d = 1'b0;
      end
    end
    if (isr_enter) begin
      pending_d = 1'b0;
    end
    if (aux_event && irq_en_d && !halt_mode) begin
      pending_d = 1'b1;
    end
    if (!irq_en_d) begin
      pending_d = 1'b0;
    end
  end

  // Reset flags are not cleared by aresetn; the reset cause loads them instead.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel_q <= CTRL_RESET[BIT_SRC_SEL];
      irq_en_q <= CTRL_RESET[BIT_IRQ_EN];
      flag_q <= CTRL_RESET[BIT_AUX_FLAG];
      pending_q <= 1'b0;
      if (lvd_reset_cause) begin
        lv_rst_q <= 1'b1;
        wdg_rst_q <= 1'b0;
      end else if (watchdog_reset_cause) begin
        wdg_rst_q <= 1'b1;
      end
    end else begin
      src_sel_q <= src_sel_d;
      irq_en_q <= irq_en_d;
      flag_q <= flag_d;
      pending_q <= pending_d;
      lv_rst_q <= lv_rst_d;
      wdg_rst_q <= wdg_rst_d;
    end
  end

  // Sticky interrupt status with write-one-to-clear; a new event beats the clear.
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (wr_fire && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == OFS_IRQ_STATUS) begin
        irq_stat_d = irq_stat_q & ~s_axi_wdata[1:0];
      end
      if (s_axi_awaddr == OFS_IRQ_MASK) begin
        irq_mask_d = s_axi_wdata[1:0];
      end
    end
    if (aux_event && !halt_mode && irq_en_d) begin
      irq_stat_d[IRQ_BIT_AUX] = 1'b1;
    end
    if (phase_q == PH_DELAY && dly_cnt_q == 13'h0000 && (lv_rst_q || wdg_rst_q)) begin
      irq_stat_d[IRQ_BIT_RESET_CAUSE] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Outputs toward the analog comparator and the CPU.
  assign monitor_source_select = src_sel_q;
  assign detector_enable = lvd_option_enable;
  assign aux_irq_request = pending_q && irq_en_q && !cpu_interrupt_mask;
  assign wakeup_request = aux_irq_request && wait_mode && !halt_mode;
  assign irq = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_flag_follows_sync: assert property (
    !halt_mode && $past(!halt_mode) && lvd_option_enable && $past(lvd_option_enable)
      |-> flag_q == $past(sync1_q, 2))
    else $error("Status flag does not follow synchronized comparator.");
  a_flag_off_no_lvd: assert property (
    !lvd_option_enable && !halt_mode |=> !flag_q || halt_mode)
    else $error("Flag active while detector option is off.");
  a_no_irq_in_delay: assert property (
    phase_q == PH_DELAY && !pending_q |=> !pending_q)
    else $error("Interrupt raised inside reset delay.");
  a_toggle_raises: assert property (
    phase_q == PH_RUN && irq_en_q && !halt_mode && $changed(flag_q) && $past(irq_en_q)
      && $past(phase_q == PH_RUN) |-> pending_q)
    else $error("Flag change did not raise pending request.");
  a_isr_clears: assert property (
    isr_enter && !(aux_event && irq_en_d) |=> !pending_q)
    else $error("Service entry did not clear pending request.");
  a_mask_gates: assert property (
    cpu_interrupt_mask |-> !aux_irq_request)
    else $error("Request passed a set CPU mask.");
  a_halt_freezes: assert property (
    halt_mode && $past(halt_mode) |-> $stable(flag_q) && !wakeup_request)
    else $error("Register changed or woke in halt.");
  a_src_sel_write: assert property (
    wr_fire && s_axi_awaddr == OFS_CTRL_STATUS && s_axi_wstrb[0] && !halt_mode
      |=> monitor_source_select == $past(s_axi_wdata[BIT_SRC_SEL]))
    else $error("Source select did not take written value.");
  a_lv_flag_keeps: assert property (
    lv_rst_q && !(wr_fire && s_axi_awaddr == OFS_CTRL_STATUS) |=> lv_rst_q)
    else $error("Low-voltage reset flag lost without a zero write.");
  // The default disable would mask this check, since it looks inside reset.
  a_lvd_clears_wdg: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn && lvd_reset_cause |=> !wdg_rst_q && lv_rst_q)
    else $error("Low-voltage reset did not clear watchdog flag.");

  // Control bits come up cleared after any reset edge.
  a_reset_ctrl_zero: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !src_sel_q && !irq_en_q && !pending_q)
    else $error("Control bits not cleared by reset.");
  a_wait_wakes: assert property (
    aux_irq_request && wait_mode && !halt_mode |-> wakeup_request)
    else $error("Request in wait did not wake.");

  // A qualified event always lands in the sticky status bit.
  a_event_sets_status: assert property (
    aux_event && irq_en_d && !halt_mode |=> irq_stat_q[IRQ_BIT_AUX])
    else $error("Event did not set the status bit.");

  // No new auxiliary status bit can appear while the start-up delay runs.
  a_delay_no_status: assert property (
    phase_q == PH_DELAY && !irq_stat_q[IRQ_BIT_AUX] |=> !irq_stat_q[IRQ_BIT_AUX])
    else $error("Status bit set inside reset delay.");

  // The delay phase ends only after the selected number of cycles.
  a_delay_length: assert property (
    phase_q == PH_RUN && $past(phase_q == PH_DELAY) |-> $past(dly_cnt_q) == dly_len - 13'h0001)
    else $error("Reset delay ended at the wrong count.");

  // Turning the enable on after the delay raises one request.
  a_enable_raises: assert property (
    phase_q == PH_RUN && en_rise && !halt_mode |=> pending_q)
    else $error("Enable rise did not raise pending request.");

  // In halt the control/status bits hold their values.
  a_halt_holds_ctrl: assert property (
    halt_mode |=> $stable(src_sel_q) && $stable(irq_en_q) && $stable(lv_rst_q) && $stable(wdg_rst_q))
    else $error("Control/status bits changed in halt.");

  // Wakeup is only offered from wait and never from halt.
  a_wake_only_wait: assert property (
    wakeup_request |-> wait_mode && !halt_mode)
    else $error("Wakeup offered outside wait.");

  // A taken write is answered on the next cycle.
  a_write_answered: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("Write response missing after taken write.");

  // The write response stands until the master accepts it.
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before acceptance.");

  // Read data stand until the master accepts them.
  a_rvalid_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before acceptance.");

  // A write to an unmapped offset is refused with an error code.
  a_unmapped_error: assert property (
    wr_fire && s_axi_awaddr != OFS_CTRL_STATUS && s_axi_awaddr != OFS_IRQ_STATUS
      && s_axi_awaddr != OFS_IRQ_MASK |=> s_axi_bresp == RESP_SLVERR)
    else $error("Unmapped write not refused.");

  // Reserved and upper bits of the control/status word read as zero.
  a_reserved_read_zero: assert property (
    $rose(s_axi_rvalid) && $past(s_axi_araddr == OFS_CTRL_STATUS)
      |-> s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[31:8] == 24'h000000)
    else $error("Reserved control/status bits read nonzero.");

  c_flag_fall: cover property (phase_q == PH_RUN ##1 $fell(flag_q) ##1 pending_q);
  c_enable_rise_event: cover property (phase_q == PH_RUN && en_rise ##1 pending_q);
  c_isr_clear: cover property (pending_q ##1 isr_enter ##1 !pending_q);
  c_irq_out: cover property ($rose(irq));
  c_wait_wakeup: cover property ($rose(wakeup_request));

endmodule : supply_monitor_reset_flags

// ### tb/sysint_partner.sv
// Purpose: Far-side model of the supply comparator and of the CPU interrupt entry.
// Assumes: The bench sets the analog level and switches servicing on or off.
// Notes: The comparator moves off the clock edge, as an analog part would.
`timescale 1ns/10ps
module sysint_partner (
  input wire logic aclk,
  input wire logic cmp_level,
  input wire logic service_on,
  input wire logic aux_irq_request,
  output logic comparator_out,
  output logic isr_enter
);
  // Comparator follows the monitored level after an analog delay.
  initial comparator_out = 1'h0;
  always @(cmp_level) comparator_out <= #7 cmp_level;
  // CPU enters the service routine for one cycle when asked and allowed.
  initial isr_enter = 1'h0;
  always @(posedge aclk) isr_enter <= service_on && aux_irq_request && !isr_enter;
endmodule : sysint_partner

// ### tb/test_supply_monitor_reset_flags.sv
// Purpose: Self-checking bench for the supply monitor and reset flag block.
// Assumes: Short delay counts of 4 and 8 cycles keep the run brief.
// Notes: Reset causes are held during reset; flags are modelled in lv and wd.
`timescale 1ns/10ps
module test_supply_monitor_reset_flags
  import sysint_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic comparator_out, lvd_option_enable, reset_delay_long, lvd_reset_cause;
  logic watchdog_reset_cause, cpu_interrupt_mask, isr_enter, wait_mode, halt_mode;
  logic monitor_source_select, detector_enable, aux_irq_request, wakeup_request, irq;
  logic cmp_level, service_on, lv, wd;
  logic [7:0] seed;
  int fail_count, compares;
  supply_monitor_reset_flags #(.DELAY_SHORT(4), .DELAY_LONG(8)) uut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_out, .lvd_option_enable, .reset_delay_long,
    .lvd_reset_cause, .watchdog_reset_cause, .cpu_interrupt_mask, .isr_enter, .wait_mode,
    .halt_mode, .monitor_source_select, .detector_enable, .aux_irq_request,
    .wakeup_request, .irq);
  sysint_partner far_side (.aclk, .cmp_level, .service_on, .aux_irq_request,
    .comparator_out, .isr_enter);
  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  // Next value of the stimulus shift register.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Expected control/status word from control bits, flag and reset flags.
  function automatic logic [31:0] exp_ctrl(input logic [7:0] c, input logic f);
    return {24'h000000, c[7:6], f, lv, 3'h0, wd};
  endfunction : exp_ctrl
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic results;
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // Bus write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 40) begin
      fail_count++;
      results;
    end
  endtask : axw
  // Bus read: address held until taken, data captured at the valid edge.
  task automatic axr(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 40) begin
      fail_count++;
      results;
    end
  endtask : axr
  // Reset with a given cause, then wait out the start-up delay.
  task automatic do_reset(input logic l, input logic w);
    @(posedge aclk);
    aresetn <= 1'h0;
    lvd_reset_cause <= l;
    watchdog_reset_cause <= w;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    lvd_reset_cause <= 1'h0;
    watchdog_reset_cause <= 1'h0;
    lv = lv | l;
    wd = l ? 1'h0 : (wd | w);
    repeat (12) @(posedge aclk);
  endtask : do_reset
  // Main sequence.
  initial begin
    {fail_count, compares, lv, wd, aresetn, lvd_reset_cause, watchdog_reset_cause} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, reset_delay_long, cpu_interrupt_mask} = '0;
    {wait_mode, halt_mode, cmp_level, service_on} = '0;
    s_axi_wstrb = 4'hF;
    lvd_option_enable = 1'h1;
    seed = 8'h57;
    do_reset(1'h1, 1'h0);
    axr(OFS_CTRL_STATUS);
    chk("ctrl after lvd reset", exp_ctrl(8'h00, 1'h0), rd);
    do_reset(1'h0, 1'h1);
    axr(OFS_CTRL_STATUS);
    chk("ctrl after wdg reset", exp_ctrl(8'h00, 1'h0), rd);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      axw(OFS_CTRL_STATUS, {24'h000000, (seed & 8'hD1) | 8'h20});
      lv = lv & seed[4];
      wd = wd & seed[0];
      axr(OFS_CTRL_STATUS);
      chk("ctrl readback", exp_ctrl(seed, 1'h0), rd);
      chk("source select", 32'(seed[7]), 32'(monitor_source_select));
    end
    axr(4'hC);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    axw(4'hC, 32'h00000000);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
    axw(OFS_IRQ_MASK, 32'h00000001);
    axw(OFS_CTRL_STATUS, 32'h00000000);
    // Writing zeros clears both reset flags in the model too.
    lv = 1'h0;
    wd = 1'h0;
    axw(OFS_IRQ_STATUS, 32'h00000003);
    axw(OFS_CTRL_STATUS, 32'h00000040);
    axr(OFS_IRQ_STATUS);
    chk("irq on enable", 32'h00000001, rd & 32'h00000001);
    chk("irq line", 32'h00000001, 32'(irq));
    axw(OFS_IRQ_STATUS, 32'h00000001);
    chk("irq cleared", 32'h00000000, 32'(irq));
    for (int i = 1; i >= 0; i--) begin
      cmp_level <= i[0];
      repeat (6) @(posedge aclk);
      axr(OFS_CTRL_STATUS);
      chk("flag", exp_ctrl(8'h40, i[0]), rd);
      axr(OFS_IRQ_STATUS);
      chk("change irq", 32'h00000001, rd & 32'h00000001);
      axw(OFS_IRQ_STATUS, 32'h00000001);
    end
    chk("aux request", 32'h00000001, 32'(aux_irq_request));
    cpu_interrupt_mask <= 1'h1;
    @(posedge aclk);
    chk("masked request", 32'h00000000, 32'(aux_irq_request));
    cpu_interrupt_mask <= 1'h0;
    wait_mode <= 1'h1;
    @(posedge aclk);
    chk("wakeup", 32'h00000001, 32'(wakeup_request));
    service_on <= 1'h1;
    repeat (4) @(posedge aclk);
    chk("serviced", 32'h00000000, 32'(aux_irq_request));
    service_on <= 1'h0;
    halt_mode <= 1'h1;
    cmp_level <= 1'h1;
    axw(OFS_CTRL_STATUS, 32'h00000080);
    repeat (6) @(posedge aclk);
    axr(OFS_CTRL_STATUS);
    chk("halt frozen", exp_ctrl(8'h40, 1'h0), rd);
    halt_mode <= 1'h0;
    wait_mode <= 1'h0;
    lvd_option_enable <= 1'h0;
    repeat (6) @(posedge aclk);
    chk("detector off", 32'h00000000, 32'(detector_enable));
    axr(OFS_CTRL_STATUS);
    chk("flag option off", exp_ctrl(8'h40, 1'h0), rd);
    lvd_option_enable <= 1'h1;
    reset_delay_long <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      do_reset(i == 1, i == 2);
      axr(OFS_CTRL_STATUS);
      chk("ctrl after reset", exp_ctrl(8'h00, 1'h1), rd);
    end
    results;
  end
endmodule : test_supply_monitor_reset_flags
